// [core/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;
    // Sizes
    localparam int NUM_SRC = 246;
    localparam int NUM_TRAP = 6;
    localparam int FLAG_BITS = 256;
    localparam int REG_BITS = 16;
    localparam int PRIO_REGS = 62;
    localparam int FIELDS_PER_REG = 4;
    localparam int FIELD_STRIDE = 4;
    localparam int PRIO_W = 3;
    localparam int LEVEL_W = 4;
    localparam int ADDR_W = 8;
    localparam int VEC_W = 8;
    localparam int PC_W = 24;

    // Register map, word indices
    localparam logic [7:0] ADDR_FLAG_FIRST = 8'h00;
    localparam logic [7:0] ADDR_FLAG_LAST = 8'h0F;
    localparam logic [7:0] ADDR_EN_FIRST = 8'h10;
    localparam logic [7:0] ADDR_EN_LAST = 8'h1F;
    localparam logic [7:0] ADDR_PRIO_FIRST = 8'h20;
    localparam logic [7:0] ADDR_PRIO_LAST = 8'h5D;
    localparam logic [7:0] ADDR_STATUS = 8'h60;
    localparam logic [7:0] ADDR_TRAP = 8'h61;

    // Reset values
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] PRIO_FIELD_MASK = 16'h7777;

    // Vector table
    localparam logic [23:0] VECTOR_TABLE_BASE = 24'h000004;
    localparam int VECTOR_STRIDE = 2;
    localparam int IRQ_VECTOR_OFFSET = 8;
    localparam int TRAP_VECTOR_FIRST = 1;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [3:0] TRAP_LEVEL = 4'h8;

    // Status register fields
    localparam int STAT_VEC_LSB = 0;
    localparam int STAT_REQ_BIT = 8;
    localparam int STAT_HOLD_BIT = 9;

    // Named request numbers
    localparam int IRQ_EXTERNAL_IRQ_ZERO = 0;
    localparam int IRQ_CHANGE_NOTICE_B = 3;
    localparam int IRQ_CAPTURE_COMPARE_ONE = 6;
    localparam int IRQ_CAPTURE_COMPARE_TIMER_ONE = 7;
    localparam int IRQ_SINGLE_BIT_ERROR_EVENT = 13;
    localparam int IRQ_NONVOLATILE_WRITE_DONE = 14;
    localparam int IRQ_I2C_TARGET_EVENT = 16;
    localparam int IRQ_SERIAL_PORT_ERROR = 49;
    localparam int IRQ_PULSE_GENERATOR_FIRST = 67;
    localparam int IRQ_PULSE_GENERATOR_LAST = 74;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } arb_state_t;
endpackage : irq_ctrl_pkg

// [core/secondary_core_interrupt_controller.sv]
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// RQ1: All peripheral request inputs merge into one CPU request output.
// RQ2: Seven software-selected priority levels, one 3-bit field per source.
// RQ3: Six trap vectors exist besides maskable ones and cannot be masked.
// RQ4: Vector table lives in program memory starting at word 000004h.
// RQ5: Up to 246 sources, each with its own vector.
// RQ6: Each vector entry holds a 24-bit handler start address.
// RQ7: Lower vector number has higher natural priority; vector 0 highest.
// RQ8: Ties within one level resolve by fixed order, never rotating.
// RQ9: Entry and return latency are constant, independent of source.
// RQ10: Only the primary vector table exists; no alternate table.
// RQ11: Reset bypasses the controller, clears registers, start address zero.
// RQ12: Software should point unused vectors at a resetting default handler.
// RQ13: External irq zero: request 0, vector 8, entry 0x000014, bit 0.
// RQ14: Flags and enables pack sixteen requests per register.
// RQ15: Priority fields 3 bits, four per register, at nibble positions.
// RQ16: Capture/compare one request 6 vector 14; its timer request 7.
// RQ17: Pulse generators use requests 67 to 74; first at vector 75.
// RQ18: Single-bit error event: request 13, vector 21, flag bit 13.
// RQ19: Nonvolatile write done: request 14, vector 22, entry 0x000030.
// RQ20: Serial port error: request 49, vector 57, fourth flag register bit 1.
// RQ21: Source qualifies if flag, enable set and level nonzero above CPU level.
// RQ22: Present highest level, lowest vector on ties, with its vector number.
module secondary_core_interrupt_controller (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] irqIn,
    input wire logic [irq_ctrl_pkg::NUM_TRAP-1:0] trapIn,
    input wire logic [irq_ctrl_pkg::LEVEL_W-1:0] cpuLevel,
    input wire logic intAck,
    input wire logic [irq_ctrl_pkg::ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    output logic cpuIrqReq,
    output logic [irq_ctrl_pkg::VEC_W-1:0] cpuIrqVector,
    output logic [irq_ctrl_pkg::PC_W-1:0] cpuEntryAddr
);
    import irq_ctrl_pkg::*;

    // Vector number of a peripheral request
    function automatic logic [VEC_W-1:0] vectorOf(input int src);
        vectorOf = VEC_W'(src + IRQ_VECTOR_OFFSET); // RQ13 RQ16 RQ17 RQ18 RQ19 RQ20
    endfunction : vectorOf

    // Table entry address of a vector; only the primary table exists
    function automatic logic [PC_W-1:0] entryOf(input logic [VEC_W-1:0] vec);
        logic [PC_W-1:0] off;
        off = PC_W'(vec) * PC_W'(VECTOR_STRIDE);
        entryOf = VECTOR_TABLE_BASE + off; // RQ4 RQ6 RQ10
    endfunction : entryOf

    // Priority field of a source within its priority word
    function automatic logic [PRIO_W-1:0] fieldOf(input logic [15:0] word, input int src);
        fieldOf = word[(src % FIELDS_PER_REG) * FIELD_STRIDE +: PRIO_W]; // RQ15 RQ2
    endfunction : fieldOf

    // Address decoders shared by the write and read paths
    function automatic logic isFlagWord(input logic [ADDR_W-1:0] a);
        isFlagWord = (a >= ADDR_FLAG_FIRST) && (a <= ADDR_FLAG_LAST);
    endfunction : isFlagWord

    function automatic logic isEnableWord(input logic [ADDR_W-1:0] a);
        isEnableWord = (a >= ADDR_EN_FIRST) && (a <= ADDR_EN_LAST);
    endfunction : isEnableWord

    function automatic logic isPrioWord(input logic [ADDR_W-1:0] a);
        isPrioWord = (a >= ADDR_PRIO_FIRST) && (a <= ADDR_PRIO_LAST);
    endfunction : isPrioWord

    // A source counts only when pending, enabled and above the CPU level
    function automatic logic qualifies(input logic flag, input logic en,
        input logic [LEVEL_W-1:0] lvl, input logic [LEVEL_W-1:0] cur);
        qualifies = flag && en && (lvl != '0) && (lvl > cur);
    endfunction : qualifies

    // Reset release through two flip-flops
    logic [1:0] rstSync;
    logic rstN;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end

    assign rstN = rstSync[1];

    // Register state
    logic [FLAG_BITS-1:0] flags;
    logic [FLAG_BITS-1:0] enables;
    logic [15:0] prio [PRIO_REGS];
    logic [NUM_TRAP-1:0] trapFlags;
    logic [FLAG_BITS-1:0] next_flags;
    logic [FLAG_BITS-1:0] next_enables;
    logic [15:0] next_prio [PRIO_REGS];
    logic [NUM_TRAP-1:0] next_trapFlags;

    // Arbitration state
    arb_state_t state;
    arb_state_t next_state;
    logic holding;
    logic next_cpuIrqReq;
    logic [VEC_W-1:0] next_cpuIrqVector;
    logic [PC_W-1:0] next_cpuEntryAddr;
    logic [15:0] next_regRdData;

    // Winner search
    logic winValid;
    logic [VEC_W-1:0] winVec;
    logic userValid;
    logic [LEVEL_W-1:0] userLevel;
    logic [VEC_W-1:0] userVec;
    logic trapValid;
    logic [VEC_W-1:0] trapVec;

    // Walk from the highest index down so the lowest index wins ties
    always_comb begin
        logic [LEVEL_W-1:0] lvl;
        lvl = '0;
        userValid = 1'b0;
        userLevel = '0;
        userVec = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            lvl = {1'b0, fieldOf(prio[i / FIELDS_PER_REG], i)};
            if (qualifies(flags[i], enables[i], lvl, cpuLevel)) begin // RQ21
                if (lvl >= userLevel) begin // RQ7 RQ8 RQ22
                    userValid = 1'b1;
                    userLevel = lvl;
                    userVec = vectorOf(i);
                end
            end
        end
    end

    // Traps ignore enables and the CPU level; the lowest trap vector wins
    always_comb begin
        trapValid = 1'b0;
        trapVec = '0;
        for (int t = NUM_TRAP - 1; t >= 0; t--) begin
            if (trapFlags[t]) begin // RQ3
                trapValid = 1'b1;
                trapVec = VEC_W'(t + TRAP_VECTOR_FIRST); // RQ7
            end
        end
    end

    // Traps outrank every user level
    always_comb begin
        if (trapValid) begin // RQ3
            winValid = 1'b1;
            winVec = trapVec;
        end else begin
            winValid = userValid;
            winVec = userVec;
        end
    end

    // Flag words: the stored value, with new events set on top
    always_comb begin
        int k;
        k = 0;
        next_flags = flags;
        if (regWr && isFlagWord(regAddr)) begin
            k = int'(regAddr - ADDR_FLAG_FIRST);
            next_flags[k * REG_BITS +: REG_BITS] = regWrData; // RQ14
        end
        // New events win over a clear in the same cycle
        next_flags[NUM_SRC-1:0] = next_flags[NUM_SRC-1:0] | irqIn; // RQ1 RQ5
        next_flags[FLAG_BITS-1:NUM_SRC] = '0;
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            flags <= '0; // RQ11
        end else begin
            flags <= next_flags;
        end
    end

    // Enable words; bits above the last source stay clear
    always_comb begin
        int k;
        k = 0;
        next_enables = enables;
        if (regWr && isEnableWord(regAddr)) begin
            k = int'(regAddr - ADDR_EN_FIRST);
            next_enables[k * REG_BITS +: REG_BITS] = regWrData; // RQ14
        end
        next_enables[FLAG_BITS-1:NUM_SRC] = '0;
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            enables <= '0; // RQ11
        end else begin
            enables <= next_enables;
        end
    end

    // Priority words; the bit above each field reads zero
    always_comb begin
        int k;
        k = 0;
        next_prio = prio;
        if (regWr && isPrioWord(regAddr)) begin
            k = int'(regAddr - ADDR_PRIO_FIRST);
            next_prio[k] = regWrData & PRIO_FIELD_MASK; // RQ15
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            for (int r = 0; r < PRIO_REGS; r++) begin
                prio[r] <= REG_RESET; // RQ11
            end
        end else begin
            prio <= next_prio;
        end
    end

    // Trap flags: write one to clear, accept clears the presented trap
    always_comb begin
        int k;
        k = 0;
        next_trapFlags = trapFlags;
        if (regWr && regAddr == ADDR_TRAP) begin
            next_trapFlags = trapFlags & ~regWrData[NUM_TRAP-1:0];
        end
        if (holding && intAck && cpuIrqVector < VEC_W'(IRQ_VECTOR_OFFSET)) begin
            k = int'(cpuIrqVector) - TRAP_VECTOR_FIRST;
            next_trapFlags[k] = 1'b0; // RQ3
        end
        // New trap events win over either clear
        next_trapFlags = next_trapFlags | trapIn; // RQ3
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            trapFlags <= '0; // RQ11
        end else begin
            trapFlags <= next_trapFlags;
        end
    end

    // Request to the CPU, one cycle after the winning flag is visible
    always_comb begin
        next_state = state;
        next_cpuIrqReq = cpuIrqReq;
        next_cpuIrqVector = cpuIrqVector;
        next_cpuEntryAddr = cpuEntryAddr;
        case (state)
            ST_IDLE: begin
                if (winValid) begin // RQ9
                    next_state = ST_HOLD;
                    next_cpuIrqReq = 1'b1; // RQ1
                    next_cpuIrqVector = winVec; // RQ22
                    next_cpuEntryAddr = entryOf(winVec); // RQ6
                end else begin
                    next_cpuIrqReq = 1'b0;
                end
            end

            ST_HOLD: begin
                if (intAck) begin
                    // Accepted: drop for one cycle before the next source
                    next_state = ST_IDLE;
                    next_cpuIrqReq = 1'b0;
                end else if (!winValid) begin
                    next_state = ST_IDLE;
                    next_cpuIrqReq = 1'b0;
                end else begin
                    // A higher source arriving meanwhile replaces the vector
                    next_cpuIrqVector = winVec; // RQ22
                    next_cpuEntryAddr = entryOf(winVec);
                end
            end

            default: begin
                next_state = ST_IDLE;
                next_cpuIrqReq = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            state <= ST_IDLE;
            cpuIrqReq <= 1'b0;
            cpuIrqVector <= '0;
            cpuEntryAddr <= RESET_ADDR; // RQ11
        end else begin
            state <= next_state;
            cpuIrqReq <= next_cpuIrqReq;
            cpuIrqVector <= next_cpuIrqVector;
            cpuEntryAddr <= next_cpuEntryAddr;
        end
    end

    // Status word: presented vector, request and holding state
    logic [15:0] statusWord;

    assign holding = (state == ST_HOLD);

    always_comb begin
        statusWord = '0;
        statusWord[STAT_VEC_LSB +: VEC_W] = cpuIrqVector;
        statusWord[STAT_REQ_BIT] = cpuIrqReq;
        statusWord[STAT_HOLD_BIT] = holding;
    end

    // Read port, data in the cycle after the strobe only
    always_comb begin
        int k;
        k = 0;
        next_regRdData = '0;
        if (regRd) begin
            if (isFlagWord(regAddr)) begin
                k = int'(regAddr - ADDR_FLAG_FIRST);
                next_regRdData = flags[k * REG_BITS +: REG_BITS]; // RQ14
            end else if (isEnableWord(regAddr)) begin
                k = int'(regAddr - ADDR_EN_FIRST);
                next_regRdData = enables[k * REG_BITS +: REG_BITS];
            end else if (isPrioWord(regAddr)) begin
                k = int'(regAddr - ADDR_PRIO_FIRST);
                next_regRdData = prio[k];
            end else if (regAddr == ADDR_STATUS) begin
                next_regRdData = statusWord;
            end else if (regAddr == ADDR_TRAP) begin
                next_regRdData[NUM_TRAP-1:0] = trapFlags;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            regRdData <= '0;
        end else begin
            regRdData <= next_regRdData;
        end
    end
endmodule : secondary_core_interrupt_controller

// [sim/irq_ctrl_assertions.sv]
`timescale 1ns/10ps
module irq_ctrl_assertions (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [3:0] cpuLevel,
    input wire logic intAck,
    input wire logic [7:0] regAddr,
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    input wire logic cpuIrqReq,
    input wire logic [7:0] cpuIrqVector,
    input wire logic [23:0] cpuEntryAddr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_ack;
        cpuIrqReq && intAck;
    endsequence
    sequence s_idle;
        !cpuIrqReq && cpuEntryAddr == 24'h000000;
    endsequence
    property p_entry;
        cpuIrqReq |-> cpuEntryAddr == 24'h000004 + {15'h0000, cpuIrqVector, 1'b0};
    endproperty
    a_entry: assert property (p_entry) else $error("entry address wrong");
    property p_range;
        cpuIrqReq |-> cpuIrqVector inside {[8'h01:8'h06], [8'h08:8'hFD]};
    endproperty
    a_range: assert property (p_range) else $error("vector out of range");
    property p_ack;
        s_ack |=> !cpuIrqReq;
    endproperty
    a_ack: assert property (p_ack) else $error("request held after accept");
    property p_rd_idle;
        !regRd |=> regRdData == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_unmapped;
        regRd && regAddr > 8'h61 |=> regRdData == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_reset;
        $rose(nrst) |-> s_idle [*2];
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not clear at reset");
    property p_mask;
        cpuIrqReq && cpuIrqVector >= 8'h08 |-> $past(cpuLevel) <= 4'h6;
    endproperty
    a_mask: assert property (p_mask) else $error("user request above cpu level");
    property p_trap;
        cpuIrqReq && $past(cpuLevel) >= 4'h8 |-> cpuIrqVector <= 8'h06;
    endproperty
    a_trap: assert property (p_trap) else $error("masked level shows user vector");
endmodule : irq_ctrl_assertions
bind secondary_core_interrupt_controller irq_ctrl_assertions irq_ctrl_assertions_i (
    .sys_clk, .nrst, .cpuLevel, .intAck, .regAddr, .regRd, .regRdData, .cpuIrqReq,
    .cpuIrqVector, .cpuEntryAddr);

// [sim/cpu_core_model.sv]
`timescale 1ns/10ps
module cpu_core_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cpuIrqReq,
    input wire logic [7:0] cpuIrqVector,
    input wire logic [3:0] ackDelay,
    output logic intAck,
    output logic [7:0] ackVec,
    output logic [7:0] ackCnt
);
    logic [3:0] waitCnt;
    // Records the vector it would fetch; every used entry points at a handler
    // Takes the single merged request after ackDelay cycles, zero never
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            intAck <= 1'b0;
            waitCnt <= 4'h0;
            ackCnt <= 8'h00;
            ackVec <= 8'h00;
        end else if (intAck || !cpuIrqReq || ackDelay == 4'h0) begin
            intAck <= 1'b0;
            waitCnt <= 4'h0;
        end else if (waitCnt + 4'h1 >= ackDelay) begin
            intAck <= 1'b1;
            ackVec <= cpuIrqVector;
            ackCnt <= ackCnt + 8'h01;
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule : cpu_core_model

// [sim/test_secondary_core_interrupt_controller.sv]
`timescale 1ns/10ps
module test_secondary_core_interrupt_controller;
    import irq_ctrl_pkg::*;
    logic sys_clk, nrst, intAck, regWr, regRd, cpuIrqReq;
    logic [245:0] irqIn;
    logic [5:0] trapIn;
    logic [3:0] cpuLevel, ackDelay;
    logic [7:0] regAddr, cpuIrqVector, ackVec, ackCnt;
    logic [15:0] regWrData, regRdData;
    logic [23:0] cpuEntryAddr;
    int error_cnt = 0;
    int comparisons = 0;
    int n, p;
    // Request, vector, table entry, level
    int rows[10][4] = '{'{0, 8, 24'h14, 1}, '{3, 11, 24'h1A, 2}, '{6, 14, 24'h20, 3},
        '{7, 15, 24'h22, 4}, '{13, 21, 24'h2E, 5}, '{14, 22, 24'h30, 6},
        '{16, 24, 24'h34, 7}, '{49, 57, 24'h76, 7}, '{67, 75, 24'h9A, 2},
        '{74, 82, 24'hA8, 4}};
    secondary_core_interrupt_controller secondary_core_interrupt_controller_i (.sys_clk,
        .nrst, .irqIn, .trapIn, .cpuLevel, .intAck, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .cpuIrqReq, .cpuIrqVector, .cpuEntryAddr);
    cpu_core_model cpu_core_model_i (.sys_clk, .nrst, .cpuIrqReq, .cpuIrqVector,
        .ackDelay, .intAck, .ackVec, .ackCnt);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task chkVal(string what, logic [23:0] exp, logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chkVal
    task chkBit(string what, logic exp, logic got);
        chkVal(what, {23'h0, exp}, {23'h0, got});
    endtask : chkBit
    task wr(logic [7:0] a, logic [15:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr
    task rd(logic [7:0] a, logic [15:0] exp, string what);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 chkVal(what, {8'h00, exp}, {8'h00, regRdData});
    endtask : rd
    task waitReq(logic exp);
        for (int i = 0; i < 8 && cpuIrqReq !== exp; i++) @(posedge sys_clk) #1;
        chkBit("request", exp, cpuIrqReq);
    endtask : waitReq
    task summarize;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
    initial begin
        nrst = 1'b0; irqIn = '0; trapIn = '0; cpuLevel = '0; ackDelay = '0;
        regWr = 1'b0; regRd = 1'b0; regAddr = '0; regWrData = '0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int r = 0; r < 10; r++) begin
            n = rows[r][0];
            p = rows[r][3];
            wr(8'(8'h10 + n / 16), 16'(1 << n % 16));
            wr(8'(8'h20 + n / 4), 16'(p << n % 4 * 4));
            cpuLevel <= 4'(p - 1);
            irqIn[n] <= 1'b1;
            @(posedge sys_clk);
            irqIn[n] <= 1'b0;
            #1 chkBit("early request", 1'b0, cpuIrqReq);
            @(posedge sys_clk);
            #1 chkBit("request", 1'b1, cpuIrqReq);
            chkVal("vector", 24'(rows[r][1]), {16'h0, cpuIrqVector});
            chkVal("entry", 24'(rows[r][2]), cpuEntryAddr);
            rd(8'(n / 16), 16'(1 << n % 16), "flag word");
            rd(8'(8'h20 + n / 4), 16'(p << n % 4 * 4), "priority word");
            cpuLevel <= 4'(p);
            waitReq(1'b0);
            wr(8'(n / 16), 16'h0);
            wr(8'(8'h10 + n / 16), 16'h0);
            wr(8'(8'h20 + n / 4), 16'h0);
        end
        // Two sources on one level, then one raised
        wr(8'h10, 16'h0008); wr(8'h13, 16'h0002); wr(8'h20, 16'h5000); wr(8'h2C, 16'h0050);
        cpuLevel <= 4'h0;
        irqIn[3] <= 1'b1; irqIn[49] <= 1'b1;
        @(posedge sys_clk);
        irqIn <= '0;
        waitReq(1'b1);
        chkVal("tie vector", 24'h0B, {16'h0, cpuIrqVector});
        wr(8'h2C, 16'h0060);
        repeat (2) @(posedge sys_clk);
        #1 chkVal("level winner", 24'h39, {16'h0, cpuIrqVector});
        rd(8'h60, 16'h0339, "status word");
        // Trap passes a full mask and is cleared by accept
        cpuLevel <= 4'h8; trapIn[0] <= 1'b1;
        @(posedge sys_clk);
        trapIn <= '0;
        repeat (3) @(posedge sys_clk);
        #1 chkVal("trap vector", 24'h01, {16'h0, cpuIrqVector});
        chkVal("trap entry", 24'h06, cpuEntryAddr);
        rd(8'h61, 16'h0001, "trap flags");
        ackDelay <= 4'h3;
        repeat (8) @(posedge sys_clk);
        #1 chkVal("ack count", 24'h01, {16'h0, ackCnt});
        rd(8'h61, 16'h0000, "trap flags after ack");
        cpuLevel <= 4'h0;
        repeat (10) @(posedge sys_clk);
        #1 chkVal("acked vector", 24'h39, {16'h0, ackVec});
        rd(8'h03, 16'h0002, "flag kept");
        ackDelay <= 4'h0;
        wr(8'h21, 16'hFFFF);
        rd(8'h21, 16'h7777, "reserved priority bits");
        rd(8'h70, 16'h0000, "unmapped");
        trapIn[2] <= 1'b1;
        @(posedge sys_clk);
        trapIn <= '0;
        rd(8'h61, 16'h0004, "trap flag set");
        wr(8'h61, 16'h0004);
        rd(8'h61, 16'h0000, "trap flag cleared");
        // Reset in mid-run with a pending request
        nrst <= 1'b0;
        @(posedge sys_clk);
        #1 chkBit("reset request", 1'b0, cpuIrqReq);
        chkVal("reset entry", 24'h000000, cpuEntryAddr);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(8'h03, 16'h0000, "flag after reset");
        rd(8'h21, 16'h0000, "priority after reset");
        summarize();
    end
endmodule : test_secondary_core_interrupt_controller
